// ### gpf_pkg.sv
// Purpose: Shared constants for the general-purpose pin function block
// Assumes: Byte-wide register port, 12-bit address
// Notes:   Registers hold four pin bits in the low nibble
package gpf_pkg;
  localparam int          NPINS          = 4;
  localparam int          AW             = 12;
  localparam int          DW             = 8;
  // Register offsets
  localparam logic [11:0] OFS_DIR        = 12'h030;
  localparam logic [11:0] OFS_ISEL2      = 12'h031;
  localparam logic [11:0] OFS_ISEL1      = 12'h032;
  localparam logic [11:0] OFS_ISEL0      = 12'h033;
  localparam logic [11:0] OFS_OSEL2      = 12'h034;
  localparam logic [11:0] OFS_OSEL1      = 12'h035;
  localparam logic [11:0] OFS_OSEL0      = 12'h036;
  localparam logic [11:0] OFS_RSVD       = 12'h037;
  localparam logic [11:0] OFS_OVAL       = 12'h038;
  localparam logic [11:0] OFS_IVAL       = 12'h20c;
  // Field position: pin n sits at bit n of the low nibble
  localparam int          PIN_LSB        = 0;
  // Reset values
  localparam logic [3:0]  RST_DIR        = 4'h0;
  localparam logic [3:0]  RST_ISEL2      = 4'h0;
  localparam logic [3:0]  RST_ISEL1      = 4'h0;
  localparam logic [3:0]  RST_ISEL0      = 4'hf;
  localparam logic [3:0]  RST_OUTPUT_ENABLE_CONTROL       = 4'h0;
  localparam logic [3:0]  RST_OVAL       = 4'h0;
  // Function codes
  localparam logic [2:0]  FN_PLAIN       = 3'h0;
  localparam logic [2:0]  FN_DEDICATED   = 3'h1;
  // Pins that own a dedicated input function
  localparam int          PIN_OE1        = 1;
  localparam int          PIN_REFSEL     = 2;
  // Synchroniser depth
  localparam int          SYNC_STAGES    = 2;
endpackage

// ### gpf_cfg_if.sv
// Purpose: Carries pin configuration from the register file to the pin logic
// Assumes: Single clock domain
// Notes:   Selector fields are reassembled per pin
interface gpf_cfg_if;
  logic [3:0]  dir;
  logic [11:0] in_fn;
  logic [11:0] out_fn;
  logic [3:0]  out_val;
  modport regs (output dir, output in_fn, output out_fn, output out_val);
  modport pins (input dir, input in_fn, input out_fn, input out_val);
endinterface

// ### gpf_sync.sv
// Purpose: Two-flop synchroniser for the four pin levels
// Assumes: Pins are asynchronous to clk
// Notes:   Only the second stage is visible outside
module gpf_sync #(
  parameter int WIDTH = gpf_pkg::NPINS
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } gpf_sync_t;

  gpf_sync_t s_r;
  gpf_sync_t s_nxt;

  // First stage feeds only the second
  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = d;
    s_nxt.sync = s_r.meta;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.sync;
endmodule

// ### gpf_top.sv
// Purpose: Configuration and readback for four general-purpose pins
// Assumes: clk at 250 MHz, synchronous active-high reset
// Notes:   Register read data appear the cycle after the read strobe
//
// Function
// - One direction bit per pin, 0 input, 1 output, reset to input
// - Synchronised plain-input pin levels readable at 0x20c, one bit per pin
// - Three-bit input selector per pin, active only in input mode
// - Selector 000 passes the pin level into its input value bit
// - Pin 2 selector 001, its reset value, drives manual reference select
// - Pin 1 selector 001, its reset value, drives output enable bit 1
// - Pin 3 has no dedicated input; 001 there is reserved
// - Selector bits spread by significance over 0x31-0x36, values at 0x38
// - Output mode with selector 000 drives the output value bit
//
// Design decision made here: the address-and-strobe port.
module gpf_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Pins
  input  wire logic [3:0]  pin_in,
  output logic      [3:0]  pin_out,
  output logic      [3:0]  pin_oe,
  // Dedicated functions
  input  wire logic [3:0]  status_flags,
  output logic             manual_reference_select,
  output logic             manual_reference_select_valid,
  output logic             output_enable_control_1,
  output logic             output_enable_control_1_valid
);
  typedef struct packed {
    logic [3:0] dir;
    logic [3:0] isel2;
    logic [3:0] isel1;
    logic [3:0] isel0;
    logic [3:0] osel2;
    logic [3:0] osel1;
    logic [3:0] osel0;
    logic [3:0] oval;
    logic [3:0] ival;
    logic [7:0] rdata;
    logic [3:0] pout;
    logic [3:0] poe;
    logic       refsel;
    logic       refsel_vld;
    logic       oe1;
    logic       oe1_vld;
  } gpf_state_t;

  gpf_state_t st_r;
  gpf_state_t st_nxt;
  logic [3:0] pin_sync;

  gpf_cfg_if cfg ();

  // Pin levels cross into clk before anything reads them
  gpf_sync #(
    .WIDTH (gpf_pkg::NPINS)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     (pin_in),
    .q     (pin_sync)
  );

  // Gather one pin's selector from the three significance registers
  function automatic logic [2:0] pin_fn(input logic [3:0] b2, input logic [3:0] b1,
                                        input logic [3:0] b0, input int n);
    pin_fn = {b2[n], b1[n], b0[n]};
  endfunction

  // Per-pin configuration view
  generate
    for (genvar n = 0; n < gpf_pkg::NPINS; n++) begin : g_cfg
      assign cfg.in_fn[3*n +: 3]  = pin_fn(st_r.isel2, st_r.isel1, st_r.isel0, n);
      assign cfg.out_fn[3*n +: 3] = pin_fn(st_r.osel2, st_r.osel1, st_r.osel0, n);
    end
  endgenerate
  assign cfg.dir     = st_r.dir;
  assign cfg.out_val = st_r.oval;

  // Next-state: register writes, readback, pin functions
  always_comb begin
    logic [3:0] rd_nib;
    logic       hit;
    logic [2:0] fn;
    rd_nib = 4'h0;
    hit    = 1'b1;
    fn     = 3'h0;
    st_nxt = st_r;

    // Writes keep only the pin nibble; upper bits are not stored
    if (reg_wr) begin
      case (reg_addr)
        gpf_pkg::OFS_DIR:   st_nxt.dir   = reg_wdata[3:0];
        gpf_pkg::OFS_ISEL2: st_nxt.isel2 = reg_wdata[3:0];
        gpf_pkg::OFS_ISEL1: st_nxt.isel1 = reg_wdata[3:0];
        gpf_pkg::OFS_ISEL0: st_nxt.isel0 = reg_wdata[3:0];
        gpf_pkg::OFS_OSEL2: st_nxt.osel2 = reg_wdata[3:0];
        gpf_pkg::OFS_OSEL1: st_nxt.osel1 = reg_wdata[3:0];
        gpf_pkg::OFS_OSEL0: st_nxt.osel0 = reg_wdata[3:0];
        gpf_pkg::OFS_OVAL:  st_nxt.oval  = reg_wdata[3:0];
        default: ;                            // Read-only and unmapped ignore writes
      endcase
    end

    // Read mux; reserved bits return zero
    case (reg_addr)
      gpf_pkg::OFS_DIR:   rd_nib = st_r.dir;
      gpf_pkg::OFS_ISEL2: rd_nib = st_r.isel2;
      gpf_pkg::OFS_ISEL1: rd_nib = st_r.isel1;
      gpf_pkg::OFS_ISEL0: rd_nib = st_r.isel0;
      gpf_pkg::OFS_OSEL2: rd_nib = st_r.osel2;
      gpf_pkg::OFS_OSEL1: rd_nib = st_r.osel1;
      gpf_pkg::OFS_OSEL0: rd_nib = st_r.osel0;
      gpf_pkg::OFS_OVAL:  rd_nib = st_r.oval;
      gpf_pkg::OFS_IVAL:  rd_nib = st_r.ival;
      default:            hit    = 1'b0;          // Unmapped and 0x37 read zero
    endcase
    st_nxt.rdata = (reg_rd && hit) ? {4'h0, rd_nib} : 8'h00;

    // Pin behaviour, one pin at a time
    for (int n = 0; n < gpf_pkg::NPINS; n++) begin
      if (cfg.dir[n]) begin
        // Output mode: plain output from value bit, code 001 a status flag
        fn            = cfg.out_fn[3*n +: 3];
        st_nxt.poe[n] = 1'b1;
        if (fn == gpf_pkg::FN_PLAIN) begin
          st_nxt.pout[n] = cfg.out_val[n];
        end else if (fn == gpf_pkg::FN_DEDICATED) begin
          st_nxt.pout[n] = status_flags[n];
        end else begin
          st_nxt.pout[n] = 1'b0;                    // Reserved codes drive low
        end
      end else begin
        fn             = cfg.in_fn[3*n +: 3];
        st_nxt.poe[n]  = 1'b0;
        st_nxt.pout[n] = 1'b0;
        // Input value holds its last level when the pin is not plain input
        if (fn == gpf_pkg::FN_PLAIN) begin
          st_nxt.ival[n] = pin_sync[n];
        end
      end
    end

    // Dedicated inputs: only in input mode with code 001
    st_nxt.refsel_vld = !st_r.dir[gpf_pkg::PIN_REFSEL] &&
                        cfg.in_fn[3*gpf_pkg::PIN_REFSEL +: 3] == gpf_pkg::FN_DEDICATED;
    st_nxt.refsel     = st_nxt.refsel_vld ? pin_sync[gpf_pkg::PIN_REFSEL] : 1'b0;
    st_nxt.oe1_vld    = !st_r.dir[gpf_pkg::PIN_OE1] &&
                        cfg.in_fn[3*gpf_pkg::PIN_OE1 +: 3] == gpf_pkg::FN_DEDICATED;
    st_nxt.oe1        = st_nxt.oe1_vld ? pin_sync[gpf_pkg::PIN_OE1] : 1'b0;
    // Pin 3 and pin 0 carry no dedicated input here; code 001 there does nothing
  end

  // State register; input selector bit 0 resets high giving 001 on every pin
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r       <= '0;
      st_r.dir   <= gpf_pkg::RST_DIR;
      st_r.isel2 <= gpf_pkg::RST_ISEL2;
      st_r.isel1 <= gpf_pkg::RST_ISEL1;
      st_r.isel0 <= gpf_pkg::RST_ISEL0;
      st_r.osel2 <= gpf_pkg::RST_OUTPUT_ENABLE_CONTROL;
      st_r.osel1 <= gpf_pkg::RST_OUTPUT_ENABLE_CONTROL;
      st_r.osel0 <= gpf_pkg::RST_OUTPUT_ENABLE_CONTROL;
      st_r.oval  <= gpf_pkg::RST_OVAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign reg_rdata                     = st_r.rdata;
  assign pin_out                       = st_r.pout;
  assign pin_oe                        = st_r.poe;
  assign manual_reference_select       = st_r.refsel;
  assign manual_reference_select_valid = st_r.refsel_vld;
  assign output_enable_control_1       = st_r.oe1;
  assign output_enable_control_1_valid = st_r.oe1_vld;
endmodule

// ### gpf_top_chk.sv
// Purpose: Port-level assertions for the pin function block
// Assumes: Single clock, synchronous active-high reset
// Notes:   Bound to gpf_top; watches only its ports
module gpf_top_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Register port and pins
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [3:0]  pin_in,
  input wire logic [3:0]  pin_out,
  input wire logic [3:0]  pin_oe,
  // Dedicated functions
  input wire logic        manual_reference_select,
  input wire logic        manual_reference_select_valid,
  input wire logic        output_enable_control_1,
  input wire logic        output_enable_control_1_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_upper; $past(reg_rd) |-> reg_rdata[7:4] == 4'h0; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper nibble set");
  property p_dir_oe;
    (reg_wr && reg_addr == gpf_pkg::OFS_DIR) ##1 !(reg_wr && reg_addr == gpf_pkg::OFS_DIR)
      |-> ##1 pin_oe == $past(reg_wdata[3:0], 2);
  endproperty
  a_dir_oe: assert property (p_dir_oe) else $error("enable not from direction");
  property p_ref_in; manual_reference_select_valid |-> !pin_oe[2]; endproperty
  a_ref_in: assert property (p_ref_in) else $error("select active in output");
  property p_oe1_in; output_enable_control_1_valid |-> !pin_oe[1]; endproperty
  a_oe1_in: assert property (p_oe1_in) else $error("enable active in output");
  property p_ref_lag;
    manual_reference_select_valid |-> manual_reference_select == $past(pin_in[2], 3);
  endproperty
  a_ref_lag: assert property (p_ref_lag) else $error("select lag wrong");
  property p_oe1_lag;
    output_enable_control_1_valid |-> output_enable_control_1 == $past(pin_in[1], 3);
  endproperty
  a_oe1_lag: assert property (p_oe1_lag) else $error("enable lag wrong");
  property p_ref_off; !manual_reference_select_valid |-> !manual_reference_select; endproperty
  a_ref_off: assert property (p_ref_off) else $error("select not idle");
  property p_out_off; (pin_out & ~pin_oe) == 4'h0; endproperty
  a_out_off: assert property (p_out_off) else $error("undriven pin high");
endmodule
bind gpf_top gpf_top_chk u_chk (.clk(clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .manual_reference_select(manual_reference_select),
  .manual_reference_select_valid(manual_reference_select_valid),
  .output_enable_control_1(output_enable_control_1),
  .output_enable_control_1_valid(output_enable_control_1_valid));

// ### gpf_board.sv
// Purpose: Board-side model of the four pins
// Assumes: No pull resistors on the pins
// Notes:   Device drive wins wherever its enable is high
module gpf_board (
  // Device side
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  // Board drive and resolved wire
  input  wire logic [3:0] drv,
  output logic      [3:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Board drives only where the device has let go, avoiding contention
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
endmodule

// ### gpf_top_bench.sv
// Purpose: Register-driven tests of the pin function block
// Assumes: 250 MHz clock, reset held 10 cycles
// Notes:   Reads are checked in the cycle after the strobe
module gpf_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata;
  logic [3:0]  drv = 4'h0, sts = 4'h5, pin_in, pin_out, pin_oe;
  logic        mrs, mrs_v, oec, oec_v;
  int          n_fail = 0, check_count = 0;
  logic [11:0] ra [10] = '{12'h030, 12'h031, 12'h032, 12'h033, 12'h034, 12'h035,
                           12'h036, 12'h037, 12'h038, 12'h040};
  logic [7:0]  rv [10] = '{8'h00, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00,
                           8'h00, 8'h00};
  // Clock, 4 ns period
  always #2 clk = ~clk;
  gpf_board u_brd (.pin_out(pin_out), .pin_oe(pin_oe), .drv(drv), .pin_in(pin_in));
  gpf_top u_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .status_flags(sts), .manual_reference_select(mrs),
    .manual_reference_select_valid(mrs_v), .output_enable_control_1(oec),
    .output_enable_control_1_valid(oec_v));
  task chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Gap cycle after each strobe keeps a signal from being set twice per step
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the roughly 70 cycles the tests need
  initial begin
    #20000;
    n_fail++;
    final_report;
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
    chk({6'h0, mrs_v, oec_v}, 8'h03);
    $display("test reset values done");
    drv <= 4'h6;
    repeat (5) @(posedge clk);
    #1 chk({6'h0, mrs, oec}, 8'h03);
    $display("test dedicated inputs done");
    wr(gpf_pkg::OFS_ISEL0, 8'h00);
    repeat (3) @(posedge clk);
    rd(gpf_pkg::OFS_IVAL, 8'h06);
    chk({6'h0, mrs_v, oec_v}, 8'h00);
    $display("test plain inputs done");
    wr(gpf_pkg::OFS_OVAL, 8'h09);
    wr(gpf_pkg::OFS_DIR, 8'h0f);
    drv <= 4'h0;
    repeat (4) @(posedge clk);
    rd(gpf_pkg::OFS_IVAL, 8'h06);
    chk({pin_oe, pin_out}, 8'hf9);
    rd(gpf_pkg::OFS_DIR, 8'h0f);
    rd(gpf_pkg::OFS_OVAL, 8'h09);
    wr(gpf_pkg::OFS_OSEL0, 8'h0f);
    repeat (2) @(posedge clk);
    #1 chk({4'h0, pin_out}, {4'h0, sts});
    rd(gpf_pkg::OFS_OSEL0, 8'h0f);
    $display("test outputs done");
    wr(gpf_pkg::OFS_DIR, 8'h00);
    wr(gpf_pkg::OFS_ISEL0, 8'h04);
    repeat (3) @(posedge clk);
    #1 chk({6'h0, mrs_v, oec_v}, 8'h02);
    $display("test per-pin select done");
    final_report;
  end
endmodule
